// [bec_bus_agent.sv]
// far-side model of the pci error pins seen by the error capture block
// assumes requests arrive as one-cycle pulses on ref_clk; pins have pull-ups
`timescale 1ns/100ps
`default_nettype none
module bec_bus_agent #(
    parameter int HOLD = 2
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic req_serr,
    input  wire logic req_perr,
    input  wire logic serr_n_o,
    input  wire logic serr_oe,
    output wire logic serr_n,
    output wire logic perr_n
);
    int serr_cnt;
    int perr_cnt;

    // a pulled-up pin returns high once every driver lets go
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serr_cnt <= 0;
            perr_cnt <= 0;
        end else begin
            serr_cnt <= req_serr ? HOLD : (serr_cnt > 0 ? serr_cnt - 1 : 0);
            perr_cnt <= req_perr ? HOLD : (perr_cnt > 0 ? perr_cnt - 1 : 0);
        end
    end

    // wired-and: the block's own drive is seen on the shared pin
    assign serr_n = ~((serr_cnt > 0) || (serr_oe && !serr_n_o));
    assign perr_n = ~(perr_cnt > 0);
endmodule // bec_bus_agent
`default_nettype wire

// [bec_pin_sync.sv]
// three-stage synchroniser for one pin input with agreement filter
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module bec_pin_sync
    import bec_pkg::*;
#(
    parameter logic IDLE = PIN_IDLE
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic pin_in,
    output var  logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r <= IDLE;
            s2_r <= IDLE;
            s3_r <= IDLE;
        end else if (ce) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // only a level seen by two later stages counts, so a glitch is dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_r <= IDLE;
        end else if (ce && (s2_r == s3_r)) begin
            level_r <= s3_r;
        end
    end

    assign level = level_r;
endmodule // bec_pin_sync
`default_nettype wire

// [bec_pkg.sv]
// constants for the bridge error capture registers
// assumes a byte-addressed register port, 32-bit data
package bec_pkg;
    localparam int          ADDR_W       = 13;
    localparam int          DATA_W       = 32;
    localparam logic [12:0] OFF_SYS_LOW  = 13'h0800;
    localparam logic [12:0] OFF_SYS_HIGH = 13'h0840;
    localparam logic [12:0] OFF_STATUS   = 13'h0880;
    localparam logic [12:0] OFF_PCI_ADDR = 13'h1040;

    // status word layout
    localparam int STAT_SYS_VALID = 31;
    localparam int SYM_LSB        = 23;
    localparam int SYM_MSB        = 30;
    localparam int STAT_PCI_VALID = 4;
    localparam int PCI_SYM_LSB    = 0;
    localparam int PCI_SYM_MSB    = 3;

    // index into the eight system bus symptom bits (bit minus SYM_LSB)
    localparam int SYM_UE_B  = 7;
    localparam int SYM_UE_A  = 6;
    localparam int SYM_CE_B  = 5;
    localparam int SYM_CE_A  = 4;
    localparam int SYM_NXM   = 3;
    localparam int SYM_APERR = 2;
    localparam int SYM_LOST  = 1;
    localparam int SYM_OVFL  = 0;
    localparam logic [7:0] SYM_HARD_MASK = 8'hCD;

    // index into the four pci symptom bits
    localparam int PCI_PTE  = 3;
    localparam int PCI_TA   = 2;
    localparam int PCI_SERR = 1;
    localparam int PCI_PERR = 0;

    // high and low capture word layout
    localparam int         HI_VALID    = 31;
    localparam int         HI_DIRTY    = 20;
    localparam int         HI_ONES_LSB = 17;
    localparam logic [2:0] HI_ONES     = 3'h7;
    localparam int         HI_SLOT_LSB = 14;
    localparam int         HI_CMD_LSB  = 8;
    localparam int         LOW_LSB     = 4;

    // values after reset
    localparam logic [7:0]  SYM_RST  = 8'h00;
    localparam logic [3:0]  PCI_RST  = 4'h0;
    localparam logic [27:0] LOW_RST  = 28'h0000000;
    localparam logic [7:0]  HIA_RST  = 8'h00;
    localparam logic [5:0]  CMD_RST  = 6'h00;
    localparam logic [2:0]  SLOT_RST = 3'h0;
    localparam logic [31:0] PADR_RST = 32'h00000000;
    localparam logic [31:0] RD_IDLE  = 32'h00000000;
    localparam logic        PIN_IDLE = 1'b1;
endpackage

// [bec_regs.sv]
// bridge error capture and logging registers
// assumes event pulses come from logic on ref_clk; pci error pins are asynchronous
// What this block does
// - on a logged system bus error capture address bits 31:4; low nibble reads zero
// - a hard error locks both system bus capture registers against later errors
// - a write that clears the last hard status symptom bit unlocks the system bus capture
// - capture contents mean nothing while the system bus valid bit is clear
// - high capture bit 31 reads as the OR of status bits 30:23
// - high capture holds slot in 16:14, command in 13:8, address 39:32 in 7:0
// - high capture bit 20 is set for a read-dirty transaction
// - status locks on hard errors; only the lost-error bit may still set
// - status stays locked until every hard error bit is cleared by writing one
// - status bit 31 is read-only, the OR of bits 30:23
// - bits 30,29 uncorrectable and 28,27 correctable ecc from halves b and a
// - bit 26 for a nonexistent memory access; reads also get a fill error
// - bit 25 for a system bus command/address parity error
// - bit 24 when an error cannot be logged because state is locked
// - bit 23 when a bridge-targeted transaction is refused for full buffers
// - status bit 4 is read-only, the OR of bits 3:0, locking the pci address
// - bit 3 for an invalid page table entry on scatter/gather
// - bit 2 on master target abort except special cycles; reads get fill error
// - bit 1 when serr is observed; drive serr on own master target abort
// - bit 0 when the pci master observes perr asserted
// - a logged pci error captures pci address bits 31:0, also in dual address
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module bec_regs
    import bec_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [DATA_W-1:0] bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output var  logic [DATA_W-1:0] bus_rdata,
    input  wire logic [39:0]       sys_addr,
    input  wire logic [5:0]        sys_cmd,
    input  wire logic [2:0]        sys_slot,
    input  wire logic              sys_rd_dirty,
    input  wire logic              sys_is_read,
    input  wire logic              ev_ue_b,
    input  wire logic              ev_ue_a,
    input  wire logic              ev_ce_b,
    input  wire logic              ev_ce_a,
    input  wire logic              ev_nxm,
    input  wire logic              ev_adr_perr,
    input  wire logic              ev_ovfl,
    input  wire logic [31:0]       pci_addr,
    input  wire logic              pci_is_read,
    input  wire logic              pci_special,
    input  wire logic              pci_master_active,
    input  wire logic              ev_invalid_page_entry,
    input  wire logic              ev_target_abort,
    input  wire logic              serr_n_i,
    input  wire logic              perr_n_i,
    output var  logic              serr_n_o,
    output var  logic              serr_oe,
    output var  logic              fill_error
);
    logic [7:0]        sym_r;
    logic [3:0]        pci_sym_r;
    logic              sys_lock_r;
    logic [27:0]       low_r;
    logic [7:0]        hia_r;
    logic [5:0]        cmd_r;
    logic [2:0]        slot_r;
    logic              dirty_r;
    logic [31:0]       padr_r;
    logic [DATA_W-1:0] rdata_r;
    logic              serr_n_r;
    logic              serr_oe_r;
    logic              fill_r;
    logic              serr_lvl;
    logic              perr_lvl;
    logic              serr_prev_r;
    logic              perr_prev_r;

    logic [7:0]        sym_set;
    logic [7:0]        sym_clr;
    logic [3:0]        pci_set;
    logic [3:0]        pci_clr;
    logic              sys_any;
    logic              sys_hard;
    logic              stat_lock;
    logic              sys_log_ok;
    logic              pci_lock;
    logic              ta_valid;
    logic              stat_wr;
    logic              unlock;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [DATA_W-1:0] status_word(input logic [7:0] s, input logic [3:0] p);
        logic [DATA_W-1:0] w;
        w = '0;
        w[STAT_SYS_VALID]          = |s;
        w[SYM_MSB:SYM_LSB]         = s;
        w[STAT_PCI_VALID]          = |p;
        w[PCI_SYM_MSB:PCI_SYM_LSB] = p;
        status_word = w;
    endfunction

    bec_pin_sync #(.IDLE(PIN_IDLE)) u_serr_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .pin_in  (serr_n_i),
        .level   (serr_lvl)
    );

    bec_pin_sync #(.IDLE(PIN_IDLE)) u_perr_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .pin_in  (perr_n_i),
        .level   (perr_lvl)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serr_prev_r <= PIN_IDLE;
            perr_prev_r <= PIN_IDLE;
        end else if (ce) begin
            serr_prev_r <= serr_lvl;
            perr_prev_r <= perr_lvl;
        end
    end

    // event decode
    always_comb begin
        sys_any  = ev_ue_b | ev_ue_a | ev_ce_b | ev_ce_a | ev_nxm | ev_adr_perr | ev_ovfl;
        sys_hard = ev_ue_b | ev_ue_a | ev_nxm | ev_adr_perr | ev_ovfl;
        stat_lock = |(sym_r & SYM_HARD_MASK);
        sys_log_ok = !sys_lock_r && !stat_lock;
        pci_lock = |pci_sym_r;
        ta_valid = ev_target_abort && !pci_special;
        stat_wr  = bus_wr && hit(bus_addr, OFF_STATUS);
        sym_clr  = stat_wr ? bus_wdata[SYM_MSB:SYM_LSB] : 8'h00;
        pci_clr  = stat_wr ? bus_wdata[PCI_SYM_MSB:PCI_SYM_LSB] : 4'h0;
        unlock   = |(sym_clr & sym_r);
        sym_set = 8'h00;
        if (sys_log_ok) begin
            sym_set[SYM_UE_B]  = ev_ue_b;
            sym_set[SYM_UE_A]  = ev_ue_a;
            sym_set[SYM_CE_B]  = ev_ce_b;
            sym_set[SYM_CE_A]  = ev_ce_a;
            sym_set[SYM_NXM]   = ev_nxm;
            sym_set[SYM_APERR] = ev_adr_perr;
            sym_set[SYM_OVFL]  = ev_ovfl;
        end
        // lost stays free to set while everything else is held
        sym_set[SYM_LOST] = sys_any && !sys_log_ok;
        pci_set = 4'h0;
        pci_set[PCI_PTE]  = ev_invalid_page_entry;
        pci_set[PCI_TA]   = ta_valid;
        pci_set[PCI_SERR] = !serr_lvl && serr_prev_r;
        pci_set[PCI_PERR] = !perr_lvl && perr_prev_r && pci_master_active;
    end

    // symptom bits: a set in the same cycle as its clear wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sym_r     <= SYM_RST;
            pci_sym_r <= PCI_RST;
        end else if (ce) begin
            sym_r     <= (sym_r & ~sym_clr) | sym_set;
            pci_sym_r <= (pci_sym_r & ~pci_clr) | pci_set;
        end
    end

    // capture lock; a hard error in the unlock cycle only sets lost, so the lock is still released
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sys_lock_r <= 1'b0;
        end else if (ce) begin
            if (sys_any && sys_hard && sys_log_ok) begin
                sys_lock_r <= 1'b1;
            end else if (unlock) begin
                sys_lock_r <= 1'b0;
            end
        end
    end

    // capture is kept even when valid is clear; software must not rely on it then
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_r   <= LOW_RST;
            hia_r   <= HIA_RST;
            cmd_r   <= CMD_RST;
            slot_r  <= SLOT_RST;
            dirty_r <= 1'b0;
        end else if (ce && sys_any && sys_log_ok) begin
            low_r   <= sys_addr[31:LOW_LSB];
            hia_r   <= sys_addr[39:32];
            cmd_r   <= sys_cmd;
            slot_r  <= sys_slot;
            dirty_r <= sys_rd_dirty;
        end
    end

    // the low 32 bits are taken as given, also in dual address cycles
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            padr_r <= PADR_RST;
        end else if (ce && (|pci_set) && !pci_lock) begin
            padr_r <= pci_addr;
        end
    end

    // serr is driven for one cycle, low while enabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serr_n_r  <= PIN_IDLE;
            serr_oe_r <= 1'b0;
            fill_r    <= 1'b0;
        end else if (ce) begin
            serr_n_r  <= !ta_valid;
            serr_oe_r <= ta_valid;
            fill_r    <= (ev_nxm && sys_is_read) || (ta_valid && pci_is_read);
        end
    end

    // read data stand for one cycle only; unmapped reads return zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= RD_IDLE;
        end else if (ce) begin
            rdata_r <= RD_IDLE;
            if (bus_rd) begin
                if (hit(bus_addr, OFF_SYS_LOW)) begin
                    rdata_r <= {low_r, 4'h0};
                end else if (hit(bus_addr, OFF_SYS_HIGH)) begin
                    rdata_r <= {|sym_r, 10'h000, dirty_r, HI_ONES, slot_r, cmd_r, hia_r};
                end else if (hit(bus_addr, OFF_STATUS)) begin
                    rdata_r <= status_word(sym_r, pci_sym_r);
                end else if (hit(bus_addr, OFF_PCI_ADDR)) begin
                    rdata_r <= padr_r;
                end
            end
        end
    end

    assign bus_rdata  = rdata_r;
    assign serr_n_o   = serr_n_r;
    assign serr_oe    = serr_oe_r;
    assign fill_error = fill_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_low_capture;
        ce && sys_any && sys_log_ok |=> low_r == $past(sys_addr[31:4]);
    endproperty
    a_low_capture: assert property (p_low_capture) else $error("low capture missed");

    property p_hard_lock;
        ce && sys_any && sys_hard && sys_log_ok ##1 ce && !unlock |=> sys_lock_r && $stable(low_r);
    endproperty
    a_hard_lock: assert property (p_hard_lock) else $error("capture not held");

    property p_unlock;
        ce && unlock && !sys_any |=> !sys_lock_r;
    endproperty
    a_unlock: assert property (p_unlock) else $error("capture not unlocked");

    property p_high_read;
        ce && bus_rd && hit(bus_addr, OFF_SYS_HIGH) |=>
            bus_rdata[HI_VALID] == $past(|sym_r) && bus_rdata[19:17] == 3'h7
            && bus_rdata[13:8] == $past(cmd_r);
    endproperty
    a_high_read: assert property (p_high_read) else $error("high capture read wrong");

    property p_status_valid;
        ce && bus_rd && hit(bus_addr, OFF_STATUS) |=>
            bus_rdata[31] == $past(|sym_r) && bus_rdata[4] == $past(|pci_sym_r);
    endproperty
    a_status_valid: assert property (p_status_valid) else $error("valid bits wrong");

    property p_stat_hold;
        ce && stat_lock && !stat_wr |=> (sym_r & 8'hFD) == ($past(sym_r) & 8'hFD);
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("locked status moved");

    property p_lost;
        ce && sys_any && !sys_log_ok |=> sym_r[SYM_LOST];
    endproperty
    a_lost: assert property (p_lost) else $error("lost error not set");

    property p_ue_b;
        ce && ev_ue_b && sys_log_ok |=> sym_r[SYM_UE_B] && sys_lock_r;
    endproperty
    a_ue_b: assert property (p_ue_b) else $error("uncorrectable b not logged");

    property p_serr_drive;
        ce && ta_valid |=> !serr_n_o && serr_oe && pci_sym_r[PCI_TA];
    endproperty
    a_serr_drive: assert property (p_serr_drive) else $error("serr not driven");

    property p_pci_cap;
        ce && (|pci_set) && !pci_lock |=> padr_r == $past(pci_addr);
    endproperty
    a_pci_cap: assert property (p_pci_cap) else $error("pci address not captured");

    property p_fill;
        ce && ev_nxm && sys_is_read |=> fill_error ##1 !fill_error || ($past(ce) && fill_error);
    endproperty
    a_fill: assert property (p_fill) else $error("fill error missing");

    property p_low_read;
        ce && bus_rd && hit(bus_addr, OFF_SYS_LOW) |=>
            bus_rdata[3:0] == 4'h0 && bus_rdata[31:4] == $past(low_r);
    endproperty
    a_low_read: assert property (p_low_read) else $error("low capture read wrong");

    property p_clear;
        ce && stat_wr && !sys_any |=> (sym_r & $past(sym_clr)) == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("symptom bit not cleared");

    property p_pci_hold;
        ce && pci_lock && !stat_wr |=> $stable(padr_r);
    endproperty
    a_pci_hold: assert property (p_pci_hold) else $error("locked pci address moved");

    property p_ta_fill;
        ce && ta_valid && pci_is_read |=> fill_error;
    endproperty
    a_ta_fill: assert property (p_ta_fill) else $error("abort read fill error missing");

    property p_special;
        ce && ev_target_abort && pci_special |=> !serr_oe && serr_n_o;
    endproperty
    a_special: assert property (p_special) else $error("special cycle drove serr");

    property p_serr_set;
        ce && !serr_lvl && serr_prev_r |=> pci_sym_r[PCI_SERR];
    endproperty
    a_serr_set: assert property (p_serr_set) else $error("serr not logged");

    property p_perr_set;
        ce && !perr_lvl && perr_prev_r && pci_master_active |=> pci_sym_r[PCI_PERR];
    endproperty
    a_perr_set: assert property (p_perr_set) else $error("perr not logged");

    c_hard_lock: cover property (ce && sys_hard && sys_log_ok ##1 sys_lock_r);
    c_lost:      cover property (ce && sys_any && !sys_log_ok);
    c_unlock:    cover property (sys_lock_r ##1 !sys_lock_r);
    c_pci_cap:   cover property (ce && (|pci_set) && !pci_lock);
endmodule // bec_regs
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the bridge error capture registers
// assumes the bench is the register master and the system bus event source
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import bec_pkg::*;
    logic              ref_clk  = 1'b0;
    logic              rst      = 1'b1;
    logic              ce       = 1'b1;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [DATA_W-1:0] bus_wdata = '0;
    logic              bus_wr   = 1'b0;
    logic              bus_rd   = 1'b0;
    logic [DATA_W-1:0] bus_rdata;
    logic [39:0]       sys_addr = '0;
    logic [5:0]        sys_cmd  = '0;
    logic [2:0]        sys_slot = '0;
    logic              sys_rd_dirty = 1'b0;
    logic              sys_is_read  = 1'b0;
    logic [7:0]        ev       = '0;
    logic [31:0]       pci_addr = '0;
    logic              pci_is_read = 1'b0;
    logic              pci_special = 1'b0;
    logic              pci_act  = 1'b0;
    logic              ev_pte   = 1'b0;
    logic              ev_ta    = 1'b0;
    logic              req_serr = 1'b0;
    logic              req_perr = 1'b0;
    wire logic         serr_n;
    wire logic         perr_n;
    logic              serr_n_o;
    logic              serr_oe;
    logic              fill_error;
    logic [31:0]       rv;
    int                errors   = 0;
    int                checked  = 0;

    always #5 ref_clk = ~ref_clk;

    bec_regs i_bec_regs (.ref_clk(ref_clk), .rst(rst), .ce(ce), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .sys_addr(sys_addr), .sys_cmd(sys_cmd), .sys_slot(sys_slot),
        .sys_rd_dirty(sys_rd_dirty), .sys_is_read(sys_is_read), .ev_ue_b(ev[SYM_UE_B]),
        .ev_ue_a(ev[SYM_UE_A]), .ev_ce_b(ev[SYM_CE_B]), .ev_ce_a(ev[SYM_CE_A]),
        .ev_nxm(ev[SYM_NXM]), .ev_adr_perr(ev[SYM_APERR]), .ev_ovfl(ev[SYM_OVFL]),
        .pci_addr(pci_addr), .pci_is_read(pci_is_read), .pci_special(pci_special),
        .pci_master_active(pci_act), .ev_invalid_page_entry(ev_pte), .ev_target_abort(ev_ta),
        .serr_n_i(serr_n), .perr_n_i(perr_n), .serr_n_o(serr_n_o), .serr_oe(serr_oe),
        .fill_error(fill_error));

    bec_bus_agent i_bec_bus_agent (.ref_clk(ref_clk), .rst(rst), .req_serr(req_serr),
        .req_perr(req_perr), .serr_n_o(serr_n_o), .serr_oe(serr_oe), .serr_n(serr_n),
        .perr_n(perr_n));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic rd(input logic [12:0] a);
        @(posedge ref_clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 rv = bus_rdata;
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    // one-cycle system bus event; returns just after the edge that takes it
    task automatic pulse(input int idx);
        @(posedge ref_clk);
        ev[idx] <= 1'b1;
        @(posedge ref_clk);
        ev <= '0;
        #1;
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp, input string msg);
        rd(a);
        check(rv, exp, msg);
    endtask

    // pin events pass a synchroniser, so poll with a bound
    task automatic wait_stat(input logic [31:0] exp);
        for (int i = 0; i < 20 && rv !== exp; i++)
            rd(OFF_STATUS);
        check(rv, exp, "status after pin event");
        if (rv !== exp)
            stop_test();
    endtask

    function automatic logic [31:0] hi(logic d, logic [2:0] s, logic [5:0] c, logic [7:0] a);
        return {1'b1, 10'h000, d, HI_ONES, s, c, a};
    endfunction

    task automatic t_reset;
        rd_chk(OFF_SYS_LOW, 32'h00000000, "low reset");
        rd_chk(OFF_SYS_HIGH, 32'h000E0000, "high reset");
        rd_chk(OFF_STATUS, 32'h00000000, "status reset");
        rd_chk(OFF_PCI_ADDR, 32'h00000000, "pci addr reset");
        wr(OFF_SYS_LOW, 32'hFFFFFFFF);
        rd_chk(OFF_SYS_LOW, 32'h00000000, "low is read-only");
        rd_chk(13'h0900, 32'h00000000, "unmapped read");
        rd_chk(OFF_SYS_HIGH, 32'h000E0000, "high read before idle");
        @(posedge ref_clk);
        #1 check(bus_rdata, 32'h00000000, "read data one cycle only");
    endtask

    task automatic t_correctable;
        sys_addr     <= 40'hA512345678;
        sys_cmd      <= 6'h2B;
        sys_slot     <= 3'h5;
        sys_rd_dirty <= 1'b1;
        pulse(SYM_CE_A);
        rd_chk(OFF_SYS_LOW, 32'h12345670, "low capture");
        rd_chk(OFF_SYS_HIGH, hi(1'b1, 3'h5, 6'h2B, 8'hA5), "high capture");
        rd_chk(OFF_STATUS, 32'h88000000, "ce half a");
        // correctable errors do not lock, so the next one reloads
        sys_addr     <= 40'h3C89ABCDEF;
        sys_cmd      <= 6'h11;
        sys_slot     <= 3'h2;
        sys_rd_dirty <= 1'b0;
        pulse(SYM_CE_B);
        rd_chk(OFF_SYS_LOW, 32'h89ABCDE0, "low reload");
        rd_chk(OFF_SYS_HIGH, hi(1'b0, 3'h2, 6'h11, 8'h3C), "high reload");
        rd_chk(OFF_STATUS, 32'h98000000, "ce both halves");
        wr(OFF_STATUS, 32'h18000000);
        rd_chk(OFF_STATUS, 32'h00000000, "ce cleared");
        rd(OFF_SYS_HIGH);
        check({31'h0, rv[HI_VALID]}, 32'h0, "high valid off");
    endtask

    task automatic t_hard_lock;
        sys_addr    <= 40'h0011112220;
        sys_is_read <= 1'b1;
        pulse(SYM_NXM);
        check({31'h0, fill_error}, 32'h1, "nxm read fill error");
        sys_addr    <= 40'h0099998880;
        sys_is_read <= 1'b0;
        pulse(SYM_APERR);
        rd_chk(OFF_STATUS, 32'h85000000, "locked, lost set");
        rd_chk(OFF_SYS_LOW, 32'h11112220, "capture held");
        wr(OFF_STATUS, 32'h01000000);
        pulse(SYM_OVFL);
        rd_chk(OFF_STATUS, 32'h85000000, "still locked");
        wr(OFF_STATUS, 32'h05000000);
        rd_chk(OFF_STATUS, 32'h00000000, "all cleared");
        pulse(SYM_APERR);
        rd_chk(OFF_SYS_LOW, 32'h99998880, "unlocked capture");
        rd_chk(OFF_STATUS, 32'h82000000, "new hard error");
        wr(OFF_STATUS, 32'h02000000);
    endtask

    task automatic t_each_event;
        int idx[7] = '{SYM_UE_B, SYM_UE_A, SYM_CE_B, SYM_CE_A, SYM_NXM, SYM_APERR, SYM_OVFL};
        foreach (idx[i]) begin
            pulse(idx[i]);
            rd_chk(OFF_STATUS, 32'h80000000 | (32'h1 << (idx[i] + SYM_LSB)), "event bit");
            wr(OFF_STATUS, 32'h1 << (idx[i] + SYM_LSB));
            rd_chk(OFF_STATUS, 32'h00000000, "event cleared");
        end
    endtask

    // a frozen block must not take an event
    task automatic t_freeze;
        ce <= 1'b0;
        pulse(SYM_UE_A);
        ce <= 1'b1;
        rd_chk(OFF_STATUS, 32'h00000000, "event ignored while frozen");
    endtask

    task automatic t_pci;
        pci_addr    <= 32'hDEADBEE0;
        pci_is_read <= 1'b1;
        @(posedge ref_clk);
        ev_ta <= 1'b1;
        @(posedge ref_clk);
        ev_ta <= 1'b0;
        #1 check({serr_oe, serr_n_o, fill_error}, 32'h5, "abort drive");
        check({31'h0, serr_n}, 32'h0, "own drive on pin");
        // own drive lasts one cycle, shorter than the pin filter, so bit 1 stays clear
        rv = '0;
        wait_stat(32'h00000014);
        rd_chk(OFF_PCI_ADDR, 32'hDEADBEE0, "pci address");
        pci_addr <= 32'h01234568;
        @(posedge ref_clk);
        ev_pte <= 1'b1;
        @(posedge ref_clk);
        ev_pte <= 1'b0;
        rd_chk(OFF_STATUS, 32'h0000001C, "invalid page entry");
        rd_chk(OFF_PCI_ADDR, 32'hDEADBEE0, "pci address locked");
        wr(OFF_STATUS, 32'h0000000F);
        pci_special <= 1'b1;
        @(posedge ref_clk);
        ev_ta <= 1'b1;
        @(posedge ref_clk);
        ev_ta <= 1'b0;
        #1 check({31'h0, serr_oe}, 32'h0, "special cycle no drive");
        pci_special <= 1'b0;
        @(posedge ref_clk);
        req_perr <= 1'b1;
        @(posedge ref_clk);
        req_perr <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rd_chk(OFF_STATUS, 32'h00000000, "perr ignored when idle");
        pci_act <= 1'b1;
        req_perr <= 1'b1;
        @(posedge ref_clk);
        req_perr <= 1'b0;
        wait_stat(32'h00000011);
        rd_chk(OFF_PCI_ADDR, 32'h01234568, "pci address new");
        wr(OFF_STATUS, 32'h00000001);
        @(posedge ref_clk);
        req_serr <= 1'b1;
        @(posedge ref_clk);
        req_serr <= 1'b0;
        wait_stat(32'h00000012);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_correctable();
        t_hard_lock();
        t_each_event();
        t_freeze();
        t_pci();
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
